// >>> logic/dsbm_master.sv
// data-side bus master: issues requests and moves data over the processor-local bus
// Operation
// - request raised to present an access; acknowledge may come in the same cycle
// - slave captures qualifiers by end of its acknowledge cycle
// - single-word requests carry byte enables; line requests leave them meaningless
// - two-bit priority driven valid while request is high
// - slave services requests in order, data of earlier request first
// - line access uses upper 27 address bits; word access uses byte enables
// - slave gives word index of the read beat within the line
// - slave acknowledges each read beat on the 64-bit read bus
// - master drives write data; slave acks each word taken
// - slave reports its bus width
// - slave holds busy while performing the operation
// - slave flags errors during data transfer
// - line moves in four 64-bit or eight 32-bit beats
// - guarded storage never accessed speculatively by slave
`timescale 1ns/1ps
module dsbm_master
#(
  parameter int unsigned DEPTH = 2
) (
  input  wire  logic                        clk,
  input  wire  logic                        rst_n,
  input  wire  logic                        abortReq,
  // user command side
  input  wire  logic                        cmdValid,
  output logic                              cmdReady,
  input  wire  logic                        cmdRead,
  input  wire  logic                        cmdLine,
  input  wire  logic [dsbm_pkg::ADDR_W-1:0] cmdAddr,
  input  wire  logic [dsbm_pkg::BE_W-1:0]   cmdByteEn,
  input  wire  logic [dsbm_pkg::PRIO_W-1:0] cmdPriority,
  input  wire  logic [3:0]                  cmdAttr,
  // user write data side
  input  wire  logic                        wrValid,
  output logic                              wrReady,
  input  wire  logic [dsbm_pkg::DATA_W-1:0] wrData,
  // user read data side
  output logic                              rdValid,
  input  wire  logic                        rdReady,
  output logic [dsbm_pkg::DATA_W-1:0]       rdData,
  output logic [dsbm_pkg::WIDX_W-1:0]       rdWordIndex,
  output logic                              rdError,
  output logic                              busError,
  output logic                              slaveBusy,
  output logic                              slaveWide,
  // bus side
  output logic                              dside_req,
  output logic                              dside_read_not_write,
  output logic [dsbm_pkg::ADDR_W-1:0]       dside_addr,
  output logic                              dside_line_size,
  output logic                              dside_attr_cacheable,
  output logic                              dside_attr_write_through,
  output logic                              dside_attr_user,
  output logic                              dside_attr_guarded,
  output logic [dsbm_pkg::BE_W-1:0]         dside_byte_en,
  output logic [dsbm_pkg::PRIO_W-1:0]       dside_req_priority,
  output logic                              dside_abort,
  output logic [dsbm_pkg::DATA_W-1:0]       dside_wr_data,
  input  wire  logic                        slave_addr_ack,
  input  wire  logic                        slave_width,
  input  wire  logic                        slave_rd_data_ack,
  input  wire  logic [dsbm_pkg::DATA_W-1:0] slave_rd_data,
  input  wire  logic [dsbm_pkg::WIDX_W-1:0] slave_rd_word_index,
  input  wire  logic                        slave_wr_data_ack,
  input  wire  logic                        slave_busy,
  input  wire  logic                        slave_error
);
  import dsbm_pkg::*;

  dsbm_state_type stateReg;
  logic [1:0] rdOutReg;
  logic       wrOutReg;
  logic       wrLineReg;
  logic [3:0] wrBeatsReg;
  logic [1:0] wrGapReg;
  logic       abortDoneReg;
  logic       isRead;
  logic       canIssue;
  logic       issue;
  logic       ackTaken;
  logic       wrLast;
  logic       wrDone;
  logic       rdLast;
  logic [3:0] rdBeatsReg;
  logic       rdLineReg;
  logic       rdLineNextReg;
  logic [3:0] wrBeatsNeed;
  logic [3:0] rdBeatsNeed;
  logic       bufInReady;
  logic [DATA_W+WIDX_W:0] bufMem [DEPTH];
  logic [$clog2(DEPTH)-1:0] bufWr;
  logic [$clog2(DEPTH)-1:0] bufRd;
  logic [$clog2(DEPTH):0]   bufCnt;

  // all bus inputs come from logic on the same clock, so no synchroniser
  assign isRead   = cmdRead;
  // outstanding limits gate every new request; write spacing gates writes only
  assign canIssue = (stateReg == DSBM_IDLE) && !abortReq &&
  // a write is taken only with its first word already waiting on wrData
                    (isRead ? (rdOutReg < 2'(MAX_READS)) : (!wrOutReg && wrGapReg == CNT_ZERO && wrValid));
  assign cmdReady = canIssue;
  assign issue    = cmdValid && canIssue;
  assign ackTaken = dside_req && slave_addr_ack;

  // request state: drop after ack, then a forced low cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= DSBM_IDLE;
    end else begin
      case (stateReg)
        DSBM_IDLE: begin
          if (abortReq) begin
            stateReg <= DSBM_ABORT;
          end else if (issue) begin
            stateReg <= DSBM_REQ;
          end
        end
        DSBM_REQ: begin
          if (abortReq) begin
            stateReg <= DSBM_ABORT;
          end else if (ackTaken) begin
            stateReg <= DSBM_GAP;
          end
        end
        DSBM_GAP: begin
          stateReg <= abortReq ? DSBM_ABORT : DSBM_IDLE;
        end
        DSBM_ABORT: begin
          stateReg <= DSBM_ABORT; // held until reset
        end
        default: begin
          stateReg <= DSBM_IDLE;
        end
      endcase
    end
  end

  // abort pulses once, only while the request is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abortDoneReg <= 1'b0;
    end else if (stateReg == DSBM_ABORT) begin
      abortDoneReg <= 1'b1;
    end
  end
  assign dside_abort = (stateReg == DSBM_REQ) && abortReq && !abortDoneReg;
  assign dside_req   = (stateReg == DSBM_REQ);

  // qualifiers loaded on issue and held through the cycle after ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dside_read_not_write     <= 1'b0;
      dside_addr               <= '0;
      dside_line_size          <= 1'b0;
      dside_attr_cacheable     <= 1'b0;
      dside_attr_write_through <= 1'b0;
      dside_attr_user          <= 1'b0;
      dside_attr_guarded       <= 1'b0;
      dside_byte_en            <= '0;
      dside_req_priority       <= '0;
    end else if (issue) begin
      dside_read_not_write     <= cmdRead;
      // line access keeps only the line-select bits
      dside_addr               <= cmdLine ? {cmdAddr[ADDR_W-1:LINE_ADDR_LSB], LINE_ADDR_LSB'(0)} : cmdAddr;
      dside_line_size          <= cmdLine;
      dside_attr_cacheable     <= cmdAttr[3];
      dside_attr_write_through <= cmdAttr[2];
      dside_attr_user          <= cmdAttr[1];
      dside_attr_guarded       <= cmdAttr[0];
      dside_byte_en            <= cmdLine ? '0 : cmdByteEn;
      dside_req_priority       <= cmdPriority;
    end
  end

  // beats per line follow the reported slave width
  assign wrBeatsNeed = wrLineReg ? (slave_width ? 4'(LINE_BEATS64) : 4'(LINE_WORDS)) : 4'h1;
  assign rdBeatsNeed = rdLineReg ? (slave_width ? 4'(LINE_BEATS64) : 4'(LINE_WORDS)) : 4'h1;
  assign wrLast = slave_wr_data_ack && (wrBeatsReg + 4'h1 >= wrBeatsNeed);
  assign wrDone = wrOutReg && wrLast;
  assign rdLast = slave_rd_data_ack && (rdBeatsReg + 4'h1 >= rdBeatsNeed);

  // one write in flight; words go out in ascending order from the user stream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrOutReg   <= 1'b0;
      wrLineReg  <= 1'b0;
      wrBeatsReg <= BEAT_ZERO;
    end else if (issue && !cmdRead) begin
      wrOutReg   <= 1'b1;
      wrLineReg  <= cmdLine;
      wrBeatsReg <= BEAT_ZERO;
    end else if (wrDone) begin
      wrOutReg   <= 1'b0;
      wrBeatsReg <= BEAT_ZERO;
    end else if (wrOutReg && slave_wr_data_ack) begin
      wrBeatsReg <= wrBeatsReg + 4'h1;
    end
  end

  // gap counter keeps the next write two cycles after last write ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrGapReg <= CNT_ZERO;
    end else if (wrDone) begin
      wrGapReg <= 2'(WR_GAP_CYC);
    end else if (wrGapReg != CNT_ZERO) begin
      wrGapReg <= wrGapReg - 2'h1;
    end
  end

  // write data register advances on each slave ack except the last
  assign wrReady = wrOutReg && slave_wr_data_ack;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dside_wr_data <= '0;
    end else if ((issue && !cmdRead) || (wrOutReg && slave_wr_data_ack && !wrLast)) begin
      dside_wr_data <= wrData;
    end
  end

  // reads retire in order, earlier request's beats first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdOutReg      <= CNT_ZERO;
      rdBeatsReg    <= BEAT_ZERO;
      rdLineReg     <= 1'b0;
      rdLineNextReg <= 1'b0;
    end else begin
      rdOutReg <= rdOutReg + 2'((issue && cmdRead) ? 1 : 0) - 2'(rdLast ? 1 : 0);
      // the size of a queued read is kept apart until the read ahead of it retires
      if (issue && cmdRead) begin
        if (rdOutReg == CNT_ZERO || (rdOutReg == 2'h1 && rdLast)) begin
          rdLineReg <= cmdLine;
        end else begin
          rdLineNextReg <= cmdLine;
        end
      end else if (rdLast && rdOutReg == 2'h2) begin
        rdLineReg <= rdLineNextReg;
      end
      if (rdLast) begin
        rdBeatsReg <= BEAT_ZERO;
      end else if (slave_rd_data_ack) begin
        rdBeatsReg <= rdBeatsReg + 4'h1;
      end
    end
  end

  // two-entry read buffer; a beat acked while both entries are full is dropped
  assign bufInReady = (bufCnt < ($clog2(DEPTH)+1)'(DEPTH));

  // storage needs no reset: only entries counted in bufCnt are ever read out
  always_ff @(posedge clk) begin
    if (slave_rd_data_ack && bufInReady) begin
      bufMem[bufWr] <= {slave_error, slave_rd_word_index, slave_rd_data};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bufWr  <= '0;
      bufRd  <= '0;
      bufCnt <= '0;
    end else begin
      if (slave_rd_data_ack && bufInReady) begin
        bufWr <= bufWr + 1'b1;
      end
      if (rdValid && rdReady) begin
        bufRd <= bufRd + 1'b1;
      end
      bufCnt <= bufCnt + (($clog2(DEPTH)+1)'(slave_rd_data_ack && bufInReady))
                       - (($clog2(DEPTH)+1)'(rdValid && rdReady));
    end
  end
  assign rdValid     = (bufCnt != '0);
  assign rdData      = bufMem[bufRd][DATA_W-1:0];
  assign rdWordIndex = bufMem[bufRd][DATA_W+WIDX_W-1:DATA_W];
  assign rdError     = bufMem[bufRd][DATA_W+WIDX_W];

  // sticky error until reset, busy and width mirrored registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busError  <= 1'b0;
      slaveBusy <= 1'b0;
      slaveWide <= 1'b0;
    end else begin
      busError  <= busError | slave_error;
      slaveBusy <= slave_busy;
      slaveWide <= slave_width;
    end
  end
endmodule : dsbm_master

// >>> logic/dsbm_pkg.sv
// constants for the data-side bus master port controller
package dsbm_pkg;
  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned DATA_W        = 64;
  localparam int unsigned BE_W          = 8;
  localparam int unsigned PRIO_W        = 2;
  localparam int unsigned WIDX_W        = 3;
  localparam int unsigned MAX_READS     = 2;
  localparam int unsigned MAX_WRITES    = 1;
  localparam int unsigned REQ_GAP_CYC   = 1;
  localparam int unsigned WR_GAP_CYC    = 2;
  localparam int unsigned LINE_WORDS    = 8;
  localparam int unsigned LINE_BEATS64  = 4;
  localparam logic [1:0]  CNT_ZERO      = 2'h0;
  localparam logic [3:0]  BEAT_ZERO     = 4'h0;
  localparam logic [4:0]  LINE_ADDR_LSB = 5'h05;

  typedef enum logic [1:0] {
    DSBM_IDLE  = 2'b00,
    DSBM_REQ   = 2'b01,
    DSBM_GAP   = 2'b10,
    DSBM_ABORT = 2'b11
  } dsbm_state_type;
endpackage : dsbm_pkg

// >>> bench/dsbm_master_properties.sv
// concurrent checks on the bus side, read-valid and error flag of the data-side master
`timescale 1ns/1ps
module dsbm_master_properties (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        dside_req,
  input wire logic        slave_addr_ack,
  input wire logic        dside_abort,
  input wire logic        dside_read_not_write,
  input wire logic        dside_line_size,
  input wire logic [31:0] dside_addr,
  input wire logic [7:0]  dside_byte_en,
  input wire logic [1:0]  dside_req_priority,
  input wire logic        slave_wr_data_ack,
  input wire logic        slave_rd_data_ack,
  input wire logic        slave_error,
  input wire logic        rdValid,
  input wire logic        busError
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_req_hold: assert property (dside_req && !slave_addr_ack && !dside_abort |=> dside_req)
    else $error("request left before acknowledge");
  a_req_drop: assert property (dside_req && slave_addr_ack |=> !dside_req)
    else $error("request still high after acknowledge");
  a_addr_stable: assert property (dside_req |=> $stable(dside_addr) && $stable(dside_byte_en))
    else $error("address moved while valid");
  a_dir_stable: assert property (dside_req |=> $stable(dside_read_not_write) && $stable(dside_line_size))
    else $error("direction or size moved while valid");
  a_prio_stable: assert property (dside_req |=> $stable(dside_req_priority))
    else $error("priority moved while valid");
  a_line_fields: assert property (dside_req && dside_line_size |-> dside_byte_en == 8'h00 && dside_addr[4:0] == 5'h00)
    else $error("line request not aligned");
  a_abort_drop: assert property (dside_abort |-> dside_req ##1 !dside_req [*4])
    else $error("abort without request or request back");
  a_write_gap: assert property (dside_req && !dside_read_not_write |-> !$past(slave_wr_data_ack) && !$past(slave_wr_data_ack, 2))
    else $error("write request too close to write ack");
  a_read_fwd: assert property (slave_rd_data_ack |=> rdValid)
    else $error("read beat not forwarded");
  a_err_sticky: assert property (slave_error || busError |=> busError)
    else $error("error flag not held");
endmodule : dsbm_master_properties

bind dsbm_master dsbm_master_properties u_props (.*);

// >>> bench/dsbm_slave_model.sv
// behavioural bus slave facing the data-side master
`timescale 1ns/1ps
module dsbm_slave_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        dside_req,
  input  wire logic        dside_read_not_write,
  input  wire logic        dside_line_size,
  input  wire logic [31:0] dside_addr,
  input  wire logic [63:0] dside_wr_data,
  input  wire logic [1:0]  slowAck,
  input  wire logic        wideSel,
  input  wire logic        errInj,
  output logic             slave_addr_ack,
  output logic             slave_width,
  output logic             slave_rd_data_ack,
  output logic [63:0]      slave_rd_data,
  output logic [2:0]       slave_rd_word_index,
  output logic             slave_wr_data_ack,
  output logic             slave_busy,
  output logic             slave_error
);
  logic [1:0]  waitCnt;
  logic [33:0] ops [$];
  logic [63:0] wrLog [$];
  int          beat;
  int          beats;
  logic [2:0]  idx;
  assign slave_addr_ack = dside_req && waitCnt == slowAck;
  assign slave_width    = wideSel;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ops.delete();
      beat = 0;
      waitCnt <= 2'h0;
      slave_rd_data_ack <= 1'b0;
      slave_wr_data_ack <= 1'b0;
      slave_busy <= 1'b0;
      slave_error <= 1'b0;
      slave_rd_data <= 64'h0;
      slave_rd_word_index <= 3'h0;
    end else begin
      if (slave_wr_data_ack) wrLog.push_back(dside_wr_data);
      waitCnt <= (dside_req && !slave_addr_ack) ? waitCnt + 2'h1 : 2'h0;
      slave_rd_data_ack <= 1'b0;
      slave_wr_data_ack <= 1'b0;
      slave_error <= 1'b0;
      // idle read lines toggle so a stale value is never mistaken for data
      slave_rd_data <= ~slave_rd_data;
      slave_rd_word_index <= ~slave_rd_word_index;
      if (ops.size() > 0) begin
        beats = !ops[0][32] ? 1 : wideSel ? 4 : 8;
        // line beats come back last word first, so the master cannot rely on order
        idx = ops[0][32] ? 3'((beats - 1 - beat) * (8 / beats)) : ops[0][4:2];
        if (ops[0][33]) begin
          slave_rd_data_ack <= 1'b1;
          slave_rd_data <= {ops[0][31:0], 29'h0, idx};
          slave_rd_word_index <= idx;
          slave_error <= errInj;
        end else begin
          slave_wr_data_ack <= 1'b1;
        end
        beat = beat + 1;
        if (beat == beats) begin
          void'(ops.pop_front());
          beat = 0;
        end
      end
      if (slave_addr_ack) ops.push_back({dside_read_not_write, dside_line_size, dside_addr});
      slave_busy <= ops.size() > 0;
    end
  end
endmodule : dsbm_slave_model

// >>> bench/tb_top.sv
// bench for the data-side master: table of transfers, then pipelining, error, abort and reset
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic rd; logic line; logic wide; logic [1:0] slow; logic err;
    logic [31:0] addr; logic [7:0] be; logic [1:0] prio; logic [3:0] attr;
  } dsbm_row_type;
  logic         clk = 1'b0, rst_n = 1'b0, abortReq = 1'b0, cmdValid = 1'b0, cmdRead = 1'b0, cmdLine = 1'b0;
  logic         wrValid = 1'b0, rdReady = 1'b1, wideSel = 1'b1, errInj = 1'b0;
  logic [31:0]  cmdAddr = 32'h0;
  logic [7:0]   cmdByteEn = 8'h0;
  logic [1:0]   cmdPriority = 2'h0, slowAck = 2'h0;
  logic [3:0]   cmdAttr = 4'h0;
  logic [63:0]  wrData = 64'h0, rdData, dside_wr_data, slave_rd_data;
  logic         cmdReady, wrReady, rdValid, rdError, busError, slaveBusy, slaveWide, dside_req, dside_abort;
  logic         dside_read_not_write, dside_line_size, dside_attr_cacheable, dside_attr_write_through;
  logic         dside_attr_user, dside_attr_guarded, slave_addr_ack, slave_width, slave_rd_data_ack;
  logic         slave_wr_data_ack, slave_busy, slave_error;
  logic [31:0]  dside_addr, la;
  logic [7:0]   dside_byte_en;
  logic [1:0]   dside_req_priority;
  logic [2:0]   rdWordIndex, slave_rd_word_index, ix;
  int           n_fail = 0, checks = 0, cyc = 0, beatN = 0, wrIdx = 0;
  dsbm_row_type rows [7], pend [$], hd;
  dsbm_master dut (.*);
  dsbm_slave_model slv (.*);
  always #4 clk = ~clk;
  function automatic int beatsOf(input dsbm_row_type r);
    return !r.line ? 1 : r.wide ? 4 : 8;
  endfunction : beatsOf
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic issue(input dsbm_row_type r);
    {cmdRead, cmdLine, cmdAddr, cmdByteEn, cmdPriority, cmdAttr} <= {r.rd, r.line, r.addr, r.be, r.prio, r.attr};
    {cmdValid, wrValid, slowAck, wideSel, errInj} <= {1'b1, !r.rd, r.slow, r.wide, r.err};
    wrData <= {r.addr, 32'h0};
    do @(negedge clk); while (!cmdReady);
    @(posedge clk);
    cmdValid <= 1'b0;
    wrData <= {r.addr, 32'h1};
    if (r.rd) pend.push_back(r);
    do @(negedge clk); while (!dside_req);
    chk({dside_read_not_write, dside_line_size, dside_attr_cacheable, dside_attr_write_through, dside_attr_user,
         dside_attr_guarded, dside_req_priority, dside_byte_en, dside_addr}, {r.rd, r.line, r.attr, r.prio,
         r.line ? 8'h00 : r.be, r.line ? {r.addr[31:5], 5'h00} : r.addr}, "request qualifiers");
    @(posedge clk);
  endtask : issue
  task automatic finish(input dsbm_row_type r);
    int n;
    n = 0;
    for (int t = 0; t < 80 && (pend.size() > 0 || (!r.rd && n < beatsOf(r))); t++) begin
      @(negedge clk);
      if (!r.rd && wrReady) begin
        @(posedge clk);
        wrData <= {r.addr, 32'(n + 2)};
        n++;
      end
    end
    @(posedge clk);
    wrValid <= 1'b0;
    @(negedge clk);
    chk({32'(pend.size()), 32'(n), slaveBusy, slaveWide}, {32'h0, r.rd ? 32'h0 : 32'(beatsOf(r)), 1'b0, r.wide},
        "beat count and slave status");
    for (int k = 0; !r.rd && k < beatsOf(r); k++) begin
      chk(slv.wrLog[wrIdx], {r.addr, 32'(k)}, "write word");
      wrIdx++;
    end
    @(posedge clk);
  endtask : finish
  always @(negedge clk) begin
    if (rst_n && rdValid) begin
      hd = pend.size() > 0 ? pend[0] : '0;
      ix = hd.line ? 3'((beatsOf(hd) - 1 - beatN) * (8 / beatsOf(hd))) : hd.addr[4:2];
      la = hd.line ? {hd.addr[31:5], 5'h00} : hd.addr;
      chk({rdError, rdWordIndex, rdData}, {hd.err, ix, la, 29'h0, ix}, "read beat");
      beatN++;
      if (beatN == beatsOf(hd) && pend.size() > 0) begin
        beatN = 0;
        void'(pend.pop_front());
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    rows = '{'{1, 0, 1, 2'h0, 0, 32'h1000_0004, 8'h0F, 2'h3, 4'hA}, '{1, 1, 1, 2'h2, 0, 32'h2000_0048, 8'hFF, 2'h1, 4'h8},
             '{1, 1, 0, 2'h0, 0, 32'h3000_00E0, 8'h00, 2'h2, 4'h1}, '{0, 0, 1, 2'h1, 0, 32'h4000_0010, 8'hF0, 2'h0, 4'h2},
             '{0, 1, 1, 2'h0, 0, 32'h5000_0020, 8'h00, 2'h3, 4'hC}, '{0, 1, 0, 2'h0, 0, 32'h6000_0000, 8'hFF, 2'h1, 4'h4},
             '{1, 0, 1, 2'h0, 1, 32'h7000_0008, 8'h3C, 2'h2, 4'h0}};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      issue(rows[i]);
      finish(rows[i]);
    end
    // a word read is issued while the line's beats still arrive: two reads outstanding
    issue(rows[1]);
    issue(rows[0]);
    finish(rows[0]);
    chk(busError, 1'b1, "error flag");
    issue('{1, 0, 1, 2'h3, 0, 32'h8000_0000, 8'h0F, 2'h0, 4'h0});
    abortReq <= 1'b1;
    @(negedge clk);
    chk(dside_abort, 1'b1, "abort pulse");
    repeat (4) @(negedge clk) chk(dside_req, 1'b0, "request after abort");
    pend.delete();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({dside_req, dside_abort, busError, rdValid}, 4'h0, "outputs in reset");
    @(posedge clk);
    abortReq <= 1'b0;
    rst_n    <= 1'b1;
    @(negedge clk);
    chk(cmdReady, 1'b1, "ready after reset");
    // a plain read must work again once reset has cleared the abort
    @(posedge clk);
    issue(rows[0]);
    finish(rows[0]);
    close_out();
  end
endmodule : tb_top
